// ---- core/bvcr_pkg.sv ----
/*
 Package for the buck voltage configuration register bank: subaddresses,
 field positions, reset values, voltage-code breakpoints and blanking time.
 Assumes a 40 MHz system clock.
*/
package bvcr_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] SUBADDR_BUCK_TWO   = 8'h17;
   localparam logic [7:0] SUBADDR_BUCK_THREE = 8'h18;
   localparam logic [7:0] SUBADDR_SLEW       = 8'h1A;
   localparam logic [7:0] RESET_BUCK_TWO     = 8'h99;
   localparam logic [7:0] RESET_BUCK_THREE   = 8'h8C;
   localparam logic [5:0] RESET_THREE_CODE   = 6'h0C;
   // Strap capture: age after reset release at which the synchroniser holds the pin
   localparam logic [1:0] STRAP_AGE_CAPTURE  = 2'h2;
   localparam logic [1:0] STRAP_AGE_DONE     = 2'h3;
   localparam int unsigned BIT_SKIP_EN       = 7;
   localparam int unsigned BIT_RESERVED      = 6;
   localparam int unsigned BIT_APPLY         = 7;
   localparam int unsigned BIT_APPLY_MONDIS  = 6;
   // Voltage decode in millivolts
   localparam int unsigned TWO_BASE_MV   = 850;
   localparam int unsigned TWO_FINE_MV   = 10;
   localparam logic [5:0]  TWO_KNEE      = 6'h32;
   localparam int unsigned TWO_COARSE_MV = 25;
   localparam int unsigned THR_BASE_MV   = 900;
   localparam int unsigned THR_FINE_MV   = 25;
   localparam logic [5:0]  THR_KNEE      = 6'h1A;
   localparam int unsigned THR_COARSE_MV = 50;
   localparam logic [5:0]  THR_TOP_CODE  = 6'h23;
   // Supervisor blanking after a write
   localparam int unsigned BLANK_MS     = 5;
   localparam int unsigned BLANK_CYCLES = (CLK_HZ / 1000) * BLANK_MS;
   typedef enum logic [1:0] {
      BVCR_IDLE  = 2'b00,
      BVCR_BLANK = 2'b01
   } bvcr_blank_state_t;
endpackage

// ---- core/bvcr_code_to_mv.sv ----
/*
 Piecewise-linear decode of a 6-bit buck voltage code to millivolts.
 Assumes a code that stays within the documented table.
*/
`timescale 1ns/100ps
`default_nettype none
module bvcr_code_to_mv #(
   parameter int unsigned BASE_MV   = 850,
   parameter int unsigned FINE_MV   = 10,
   parameter logic [5:0]  KNEE      = 6'h32,
   parameter int unsigned COARSE_MV = 25
) (
   // Code in, millivolts out
   input  wire logic [5:0]  code_in,
   output logic      [11:0] mv_out
);
   // Largest result sits at code 3Fh; refuse a table that overflows 12 bits
   if (BASE_MV + FINE_MV * KNEE + COARSE_MV * (63 - KNEE) > 4095) begin : g_range_check
      $error("bvcr_code_to_mv: range exceeds 12 bits");
   end
   // Fine steps up to the knee, coarse steps beyond it
   always_comb begin
      if (code_in <= KNEE) begin
         mv_out = 12'(BASE_MV + FINE_MV * code_in);
      end else begin
         mv_out = 12'(BASE_MV + FINE_MV * KNEE + COARSE_MV * (code_in - KNEE));
      end
   end
endmodule
`default_nettype wire

// ---- core/bvcr_regs.sv ----
/*
 Register bank for the second and third step-down converters: the voltage
 code and pulse-skip enable of each, write blanking of the supervisor, and
 decoded target voltages. Assumes the serial management bus front end gives
 one-cycle write strobes with subaddress and data on clk_sys_in, and that it
 reports a completed password unlock as a one-cycle pulse.
*/
// Contract
// - Second converter code: 0.850 V, 10 mV steps to 32h, then 25 mV to 3Fh.
// - Third converter code resets Ch; 0.900 V, 25 mV to 1Ah, then 50 mV.
// - Third converter register sits at 0x18 and resets to 0x8C.
// - Writes take effect only after an unlock; host unlocks before each write (writes to 0x1A need no unlock).
// - Third converter write blanks over/undervoltage monitoring for 5 ms.
// - Bit 7 is pulse-skip enable, resets 1; 0 forces fixed frequency.
// - Skip mode entered only when enabled and the load allows it.
// - Resistor-select input may change the third converter's reset code.
// - Second converter code applies only on apply strobe at 0x1A.
// - Second converter register sits at 0x17 and resets to 0x99.
`timescale 1ns/100ps
`default_nettype none
module bvcr_regs
   import bvcr_pkg::*;
#(
   parameter int unsigned BLANK_COUNT = BLANK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   // Register access from the bus front end
   input  wire logic        wr_en_in,
   input  wire logic        rd_en_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        unlock_in,
   output logic      [7:0]  rdata_out,
   // Strap and converter status pins
   input  wire logic [5:0]  resistor_select_input_in,
   input  wire logic        light_load_in,
   // Converter controls
   output logic      [5:0]  buck_two_voltage_code_out,
   output logic      [11:0] buck_two_mv_out,
   output logic             buck_two_skip_out,
   output logic      [5:0]  buck_three_voltage_code_out,
   output logic      [11:0] buck_three_mv_out,
   output logic             buck_three_skip_out,
   output logic             monitor_blank_out
);
   // Counter is 24 bits wide, and a zero count would wrap to the longest blanking
   if (BLANK_COUNT < 1 || BLANK_COUNT > 32'h00FFFFFF) begin : g_blank_check
      $error("bvcr_regs: BLANK_COUNT out of range");
   end

   logic [7:0]  two_q, two_d, thr_q, thr_d, rdata_q, rdata_d;
   logic [5:0]  two_app_q, two_app_d;
   logic        unlocked_q, unlocked_d;
   logic [1:0]  strap_age_q, strap_age_d;
   logic        two_skip_q, two_skip_d, thr_skip_q, thr_skip_d;
   logic        ll_m_q, ll_q, blank_out_q;
   logic [5:0]  resistor_select_input_m_q, resistor_select_input_q;
   logic [23:0] cnt_q, cnt_d;
   bvcr_blank_state_t st_q, st_d;
   logic [11:0] two_mv_w, thr_mv_w, two_mv_q, thr_mv_q;
   logic        wr_ok, wr_two, wr_thr, wr_slew;

   // Two-flop synchronisers for the pins
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         resistor_select_input_m_q <= 6'h00;
         resistor_select_input_q   <= 6'h00;
         ll_m_q   <= 1'b0;
         ll_q     <= 1'b0;
      end else begin
         resistor_select_input_m_q <= resistor_select_input_in;
         resistor_select_input_q   <= resistor_select_input_m_q;
         ll_m_q   <= light_load_in;
         ll_q     <= ll_m_q;
      end
   end

   // Unlock is single use: consumed by the next write attempt at 0x17 or 0x18
   assign wr_ok   = wr_en_in && unlocked_q;
   assign wr_two  = wr_ok && addr_in == SUBADDR_BUCK_TWO;
   assign wr_thr  = wr_ok && addr_in == SUBADDR_BUCK_THREE;
   assign wr_slew = wr_en_in && addr_in == SUBADDR_SLEW;

   // Register next state
   always_comb begin
      two_d        = two_q;
      thr_d        = thr_q;
      two_app_d    = two_app_q;
      unlocked_d   = unlocked_q;
      strap_age_d  = strap_age_q;
      if (strap_age_q != STRAP_AGE_DONE) begin
         strap_age_d = strap_age_q + 2'h1;
      end
      if (unlock_in) begin
         unlocked_d = 1'b1;
      end else if (wr_en_in && (addr_in == SUBADDR_BUCK_TWO || addr_in == SUBADDR_BUCK_THREE)) begin
         unlocked_d = 1'b0;
      end
      // Strap taken once, on the third edge after release, when the second
      // synchroniser flop holds the pin; later pin changes are ignored
      if (strap_age_q == STRAP_AGE_CAPTURE && resistor_select_input_q != 6'h00) begin
         thr_d[5:0] = resistor_select_input_q;
      end
      if (wr_two) begin
         two_d = {wdata_in[BIT_SKIP_EN], 1'b0, wdata_in[5:0]};
      end
      if (wr_thr) begin
         thr_d = {wdata_in[BIT_SKIP_EN], 1'b0, wdata_in[5:0]};
      end
      // New code reaches the converter only on an apply strobe
      if (wr_slew && (wdata_in[BIT_APPLY] || wdata_in[BIT_APPLY_MONDIS])) begin
         two_app_d = two_q[5:0];
      end
      rdata_d = rdata_q;
      if (rd_en_in) begin
         case (addr_in)
            SUBADDR_BUCK_TWO:   rdata_d = two_q;
            SUBADDR_BUCK_THREE: rdata_d = thr_q;
            default:            rdata_d = 8'h00;
         endcase
      end
      // Skip mode only if allowed and the load is light
      two_skip_d = two_q[BIT_SKIP_EN] && ll_q;
      thr_skip_d = thr_q[BIT_SKIP_EN] && ll_q;
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         two_q        <= RESET_BUCK_TWO;
         thr_q        <= RESET_BUCK_THREE;
         two_app_q    <= RESET_BUCK_TWO[5:0];
         unlocked_q   <= 1'b0;
         strap_age_q  <= 2'h0;
         rdata_q      <= 8'h00;
         two_skip_q   <= 1'b0;
         thr_skip_q   <= 1'b0;
      end else begin
         two_q        <= two_d;
         thr_q        <= thr_d;
         two_app_q    <= two_app_d;
         unlocked_q   <= unlocked_d;
         strap_age_q  <= strap_age_d;
         rdata_q      <= rdata_d;
         two_skip_q   <= two_skip_d;
         thr_skip_q   <= thr_skip_d;
      end
   end

   // Blanking timer, restarted by every accepted third-converter write
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         BVCR_IDLE: begin
            if (wr_thr) begin
               st_d  = BVCR_BLANK;
               cnt_d = 24'(BLANK_COUNT - 1);
            end
         end
         BVCR_BLANK: begin
            if (wr_thr) begin
               cnt_d = 24'(BLANK_COUNT - 1);
            end else if (cnt_q == 24'h000000) begin
               st_d = BVCR_IDLE;
            end else begin
               cnt_d = cnt_q - 24'h000001;
            end
         end
         default: begin
            st_d  = BVCR_IDLE;
            cnt_d = 24'h000000;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_q        <= BVCR_IDLE;
         cnt_q       <= 24'h000000;
         blank_out_q <= 1'b0;
      end else begin
         st_q        <= st_d;
         cnt_q       <= cnt_d;
         blank_out_q <= st_d == BVCR_BLANK;
      end
   end

   // Voltage decoders
   bvcr_code_to_mv #(.BASE_MV(TWO_BASE_MV), .FINE_MV(TWO_FINE_MV), .KNEE(TWO_KNEE),
                     .COARSE_MV(TWO_COARSE_MV)) u_two_mv (
      .code_in (two_app_q),
      .mv_out  (two_mv_w)
   );
   bvcr_code_to_mv #(.BASE_MV(THR_BASE_MV), .FINE_MV(THR_FINE_MV), .KNEE(THR_KNEE),
                     .COARSE_MV(THR_COARSE_MV)) u_thr_mv (
      .code_in (thr_q[5:0]),
      .mv_out  (thr_mv_w)
   );

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         two_mv_q <= 12'h000;
         thr_mv_q <= 12'h000;
      end else begin
         two_mv_q <= two_mv_w;
         thr_mv_q <= thr_mv_w;
      end
   end

   assign rdata_out                   = rdata_q;
   assign buck_two_voltage_code_out   = two_app_q;
   assign buck_two_mv_out             = two_mv_q;
   assign buck_two_skip_out           = two_skip_q;
   assign buck_three_voltage_code_out = thr_q[5:0];
   assign buck_three_mv_out           = thr_mv_q;
   assign buck_three_skip_out         = thr_skip_q;
   assign monitor_blank_out           = blank_out_q;

   // Checks
   property p_locked_write_ignored;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (wr_en_in && !unlocked_q && !unlock_in && addr_in == SUBADDR_BUCK_THREE) |=> $stable(thr_q);
   endproperty
   a_locked_write_ignored: assert property (p_locked_write_ignored) else $error("locked write changed register");
   property p_blank_starts;
      @(posedge clk_sys_in) disable iff (sys_rst_in) wr_thr |=> monitor_blank_out;
   endproperty
   a_blank_starts: assert property (p_blank_starts) else $error("blanking did not start");
   property p_reserved_zero;
      @(posedge clk_sys_in) disable iff (sys_rst_in) !thr_q[BIT_RESERVED] && !two_q[BIT_RESERVED];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
   property p_skip_needs_enable;
      @(posedge clk_sys_in) disable iff (sys_rst_in) !thr_q[BIT_SKIP_EN] |=> !buck_three_skip_out;
   endproperty
   a_skip_needs_enable: assert property (p_skip_needs_enable) else $error("skip without enable");
   property p_skip_needs_load;
      @(posedge clk_sys_in) disable iff (sys_rst_in) !ll_q |=> !buck_two_skip_out && !buck_three_skip_out;
   endproperty
   a_skip_needs_load: assert property (p_skip_needs_load) else $error("skip at heavy load");
   property p_apply_only_on_strobe;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      !(wr_slew && (wdata_in[BIT_APPLY] || wdata_in[BIT_APPLY_MONDIS])) |=> $stable(two_app_q);
   endproperty
   a_apply_only_on_strobe: assert property (p_apply_only_on_strobe) else $error("code applied without strobe");
   property p_write_stores;
      @(posedge clk_sys_in) disable iff (sys_rst_in) wr_two |=> two_q[5:0] == $past(wdata_in[5:0]);
   endproperty
   a_write_stores: assert property (p_write_stores) else $error("write not stored");
   property p_readback;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      (rd_en_in && addr_in == SUBADDR_BUCK_THREE && !wr_thr) |=> rdata_out == thr_q;
   endproperty
   a_readback: assert property (p_readback) else $error("readback mismatch");
   property p_mv_top;
      @(posedge clk_sys_in) disable iff (sys_rst_in)
      thr_q[5:0] == THR_TOP_CODE |=> buck_three_mv_out == 12'h7D0;
   endproperty
   a_mv_top: assert property (p_mv_top) else $error("third converter decode wrong");
   property p_mv_two_top;
      @(posedge clk_sys_in) disable iff (sys_rst_in) two_app_q == 6'h3F |=> buck_two_mv_out == 12'h68B;
   endproperty
   a_mv_two_top: assert property (p_mv_two_top) else $error("second converter decode wrong");
   c_write_three: cover property (@(posedge clk_sys_in) wr_thr);
   c_blank_end: cover property (@(posedge clk_sys_in) $fell(monitor_blank_out));
   c_apply: cover property (@(posedge clk_sys_in) wr_slew && wdata_in[BIT_APPLY]);
endmodule
`default_nettype wire

// ---- dv/bvcr_host_model.sv ----
/*
 Host stand-in on the bank's register side: unlock pulse, write and read.
 Assumes the bank samples every strobe on the rising edge of clk_sys_in.
*/
`timescale 1ns/100ps
`default_nettype none
module bvcr_host_model (
   // Clock
   input  wire logic       clk_sys_in,
   // Requests to the bank
   output logic            wr_en_out,
   output logic            rd_en_out,
   output logic            unlock_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out,
   // Answer from the bank
   input  wire logic [7:0] rdata_in
);
   // Quiet bus from time zero
   initial begin
      wr_en_out  = 1'b0;
      rd_en_out  = 1'b0;
      unlock_out = 1'b0;
      addr_out   = 8'h00;
      wdata_out  = 8'h00;
   end
   // Released lines show the inverse so a stale value cannot pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
      if (unl) begin
         @(posedge clk_sys_in);
         unlock_out <= 1'b1;
      end
      @(posedge clk_sys_in);
      unlock_out <= 1'b0;
      wr_en_out  <= 1'b1;
      addr_out   <= a;
      wdata_out  <= d;
      @(posedge clk_sys_in);
      wr_en_out  <= 1'b0;
      addr_out   <= ~a;
      wdata_out  <= ~d;
   endtask
   // Data is taken after the edge that sampled the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      rd_en_out <= 1'b1;
      addr_out  <= a;
      @(posedge clk_sys_in);
      rd_en_out <= 1'b0;
      addr_out  <= ~a;
      #1 d = rdata_in;
   endtask
endmodule
`default_nettype wire

// ---- dv/buck_voltage_config_regs_tb.sv ----
/*
 Self-checking bench for the buck register bank, driven through the host model.
 Assumes a short blanking count so the run stays brief.
*/
`timescale 1ns/100ps
`default_nettype none
module buck_voltage_config_regs_tb;
   import bvcr_pkg::*;
   localparam int unsigned BLANK_N = 20;
   logic        clk_sys_in, sys_rst_in, wr_en, rd_en, unlock, light_load, skip_two, skip_three, blank;
   logic [7:0]  addr, wdata, rdata;
   logic [5:0]  resistor_select_input, code_two, code_three;
   logic [11:0] mv_two, mv_three;
   int          n_mismatch, check_count, cycles;
   // Clock only; pins are driven by the main sequence alone
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   bvcr_host_model i_host (.clk_sys_in(clk_sys_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
      .unlock_out(unlock), .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));
   bvcr_regs #(.BLANK_COUNT(BLANK_N)) i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .unlock_in(unlock),
      .rdata_out(rdata), .resistor_select_input_in(resistor_select_input), .light_load_in(light_load),
      .buck_two_voltage_code_out(code_two), .buck_two_mv_out(mv_two), .buck_two_skip_out(skip_two),
      .buck_three_voltage_code_out(code_three), .buck_three_mv_out(mv_three),
      .buck_three_skip_out(skip_three), .monitor_blank_out(blank));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   // Strap is set before reset so the capture window sees a stable value
   task automatic do_reset(input logic [5:0] strap);
      resistor_select_input <= strap;
      sys_rst_in <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      settle(6);
   endtask
   task automatic t_reset();
      logic [7:0] d;
      i_host.rd(SUBADDR_BUCK_THREE, d);
      chk(d, RESET_BUCK_THREE);
      i_host.rd(SUBADDR_BUCK_TWO, d);
      chk(d, RESET_BUCK_TWO);
      i_host.rd(8'h20, d);
      chk(d, 8'h00);
      chk(code_three, RESET_THREE_CODE);
      chk(mv_three, 12'h4B0);
      chk(mv_two, 12'h44C);
      chk(skip_three, 1'b1);
      light_load <= 1'b0;
      settle(4);
      chk(skip_three, 1'b0);
      chk(skip_two, 1'b0);
      light_load <= 1'b1;
      settle(4);
      $display("test reset done");
   endtask
   task automatic t_locked();
      logic [7:0] d;
      i_host.wr(SUBADDR_BUCK_THREE, 8'h01, 1'b0);
      settle(1);
      chk(blank, 1'b0);
      i_host.rd(SUBADDR_BUCK_THREE, d);
      chk(d, RESET_BUCK_THREE);
      $display("test locked done");
   endtask
   task automatic t_three();
      logic [7:0]  d;
      logic [5:0]  codes[4] = '{6'h00, 6'h1A, 6'h1B, 6'h23};
      logic [11:0] mvs[4] = '{12'h384, 12'h60E, 12'h640, 12'h7D0};
      int n;
      n = 0;
      i_host.wr(SUBADDR_BUCK_THREE, 8'h45, 1'b1);
      #1;
      // Bounded wait so a stuck blanking flag cannot hang the run
      while (blank === 1'b1 && n < 100) begin
         n++;
         settle(1);
      end
      chk(n, BLANK_N);
      i_host.rd(SUBADDR_BUCK_THREE, d);
      chk(d, 8'h05);
      chk(skip_three, 1'b0);
      for (int i = 0; i < 4; i++) begin
         i_host.wr(SUBADDR_BUCK_THREE, {2'b10, codes[i]}, 1'b1);
         settle(3);
         chk(mv_three, mvs[i]);
      end
      $display("test three done");
   endtask
   task automatic t_two();
      logic [7:0]  d;
      logic [5:0]  codes[3] = '{6'h32, 6'h3F, 6'h00};
      logic [7:0]  strobes[3] = '{8'h80, 8'h40, 8'h80};
      logic [11:0] mvs[3] = '{12'h546, 12'h68B, 12'h352};
      i_host.wr(SUBADDR_BUCK_TWO, 8'hB2, 1'b1);
      settle(3);
      chk(code_two, 6'h19);
      i_host.rd(SUBADDR_BUCK_TWO, d);
      chk(d, 8'hB2);
      for (int i = 0; i < 3; i++) begin
         i_host.wr(SUBADDR_BUCK_TWO, {2'b10, codes[i]}, 1'b1);
         i_host.wr(SUBADDR_SLEW, strobes[i], 1'b0);
         settle(3);
         chk(code_two, codes[i]);
         chk(mv_two, mvs[i]);
      end
      $display("test two done");
   endtask
   task automatic t_strap();
      logic [7:0] d;
      do_reset(6'h10);
      i_host.rd(SUBADDR_BUCK_THREE, d);
      chk(d, 8'h90);
      chk(code_three, 6'h10);
      do_reset(6'h00);
      $display("test strap done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the roughly 150 cycles the tests need
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   // Main sequence
   initial begin
      light_load <= 1'b1;
      do_reset(6'h00);
      t_reset();
      t_locked();
      t_three();
      t_two();
      t_strap();
      summarize();
   end
endmodule
`default_nettype wire
